/* hw/conv_mgmt_pkg.sv */
package conv_mgmt_pkg;
  // clock and time base
  localparam int CLK_PERIOD_NS = 10;
  localparam int CLK_KHZ       = 1000000 / CLK_PERIOD_NS;
  localparam int SLEW_TICK_NS  = 1000;
  localparam int SLEW_TICK_CYC = (SLEW_TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [15:0] SLEW_ACC_UNIT = 16'h03e8;

  // switching frequency, kHz
  localparam logic [15:0] FSW_DEFAULT_KHZ = 16'h00b4;
  localparam logic [15:0] FSW_MIN_KHZ     = 16'h00a0;
  localparam logic [15:0] FSW_MAX_KHZ     = 16'h00c8;

  // interleave fields
  localparam int IL_ORDER_LSB = 0;
  localparam int IL_NUM_LSB   = 4;
  localparam int IL_GROUP_LSB = 8;

  // header pin function bits
  localparam int PIN_OD_BIT       = 1;
  localparam int PIN_PG_FUNC_BIT  = 2;
  localparam int PIN_SYNC_EN_BIT  = 3;
  localparam int PIN_SYNC_DRV_BIT = 4;
  localparam logic [15:0] PIN_CFG_STANDALONE = 16'h0004;
  localparam logic [15:0] PIN_CFG_PARALLEL   = 16'h0006;

  // polarity codes
  localparam logic [7:0] POL_ACTIVE_LOW  = 8'h00;
  localparam logic [7:0] POL_ACTIVE_HIGH = 8'h01;

  // status word
  localparam logic [7:0] CMD_STATUS_WORD = 8'h79;
  localparam int STATUS_PG_N_BIT  = 11;
  localparam int STATUS_FAULT_BIT = 0;

  // adaptive factors, unsigned q4.4
  localparam logic [7:0] FACTOR_UNITY = 8'h10;
  localparam int K3_EN_ART_BIT = 8;
  localparam int K3_EN_LLC_BIT = 9;

  // configuration words: index, command code, reset value, writable bits
  localparam int NCFG = 24;
  localparam int IDX_INTERLEAVE = 0,  IDX_PG_POL = 1,   IDX_ADDR_OFS = 2,  IDX_PIN_CFG = 3;
  localparam int IDX_VOUT_SET = 4,    IDX_VOUT_RATE = 5, IDX_FSW = 6,      IDX_PG_ON = 7;
  localparam int IDX_PG_OFF = 8,      IDX_TON_RISE = 9,  IDX_LBV_V1 = 10,  IDX_LBV_V2 = 11;
  localparam int IDX_I_LO_MID = 12,   IDX_I_MID_LO = 13, IDX_I_MID_HI = 14, IDX_I_HI_MID = 15;
  localparam int IDX_LBV_EN = 16,     IDX_CAP_VSTART = 17, IDX_CAP_VEND = 18, IDX_LIM1 = 19;
  localparam int IDX_LIM2 = 20,       IDX_LIM3 = 21,     IDX_K12 = 22,     IDX_K3 = 23;

  localparam logic [7:0] CFG_CODE [NCFG] = '{
    8'h37, 8'hd0, 8'hee, 8'hf9, 8'h21, 8'h27, 8'h33, 8'h5e,
    8'h5f, 8'h61, 8'he0, 8'he1, 8'he2, 8'he3, 8'he4, 8'he5,
    8'he6, 8'hf0, 8'hf1, 8'hf2, 8'hf3, 8'hf4, 8'hf5, 8'hf6};
  localparam logic [15:0] CFG_RESET [NCFG] = '{
    16'h0021, 16'h0000, 16'h0000, PIN_CFG_STANDALONE, 16'h2ee0, 16'h00fa,
    FSW_DEFAULT_KHZ, 16'h1f40, 16'h1388, 16'h0064, 16'h2710, 16'h2af8,
    16'h1388, 16'h0fa0, 16'h61a8, 16'h59d8, 16'h0000, 16'h03e8,
    16'h1f40, 16'h03e8, 16'h07d0, 16'h0bb8, 16'h1814, 16'h0020};
  localparam logic [15:0] CFG_MASK [NCFG] = '{
    16'h3fff, 16'h00ff, 16'h00ff, 16'h00ff, 16'hffff, 16'hffff,
    16'hffff, 16'hffff, 16'hffff, 16'hffff, 16'hffff, 16'hffff,
    16'hffff, 16'hffff, 16'hffff, 16'hffff, 16'h0001, 16'hffff,
    16'hffff, 16'hffff, 16'hffff, 16'hffff, 16'hffff, 16'h03ff};

  typedef enum logic [2:0] {
    LVL_LOW  = 3'b001,
    LVL_MID  = 3'b010,
    LVL_HIGH = 3'b100
  } bus_level_t;

  typedef enum logic [2:0] {
    WIN_IDLE = 3'b001,
    WIN_OPEN = 3'b010,
    WIN_DONE = 3'b100
  } cap_win_t;
endpackage

/* hw/switch_phase_timer.sv */
module switch_phase_timer #(
  parameter int CLK_KHZ_P = 100000
) (
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic [15:0] freq_khz,
  input  wire logic        sync_en,
  input  wire logic        sync_drv,
  input  wire logic        sync_in,
  input  wire logic [3:0]  order,
  input  wire logic [3:0]  num,
  output logic             sync_out,
  output logic             phase_tick
);
  logic [31:0] period;
  logic [31:0] offset;
  logic [15:0] cnt_r;
  logic        sync_prev_r;
  logic        sync_rise;

  if (CLK_KHZ_P < 1000) begin : g_chk
    $error("clock too slow for switching timer");
  end

  assign period    = 32'(CLK_KHZ_P) / {16'h0000, freq_khz};
  // order at or beyond a non-zero group size gives an offset past the last count, so no tick
  assign offset    = (num == 4'h0) ? 32'h0 : (period * 32'(order)) / 32'(num);
  assign sync_rise = sync_in & ~sync_prev_r;

  always_ff @(posedge clk) begin
    if (srst) sync_prev_r <= 1'b0;
    else sync_prev_r <= sync_in;
  end

  always_ff @(posedge clk) begin
    if (srst) cnt_r <= 16'h0000;
    else if (sync_en && !sync_drv && sync_rise) cnt_r <= 16'h0000;
    else if (32'(cnt_r) >= period - 32'd1) cnt_r <= 16'h0000;
    else cnt_r <= cnt_r + 16'h0001;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      sync_out   <= 1'b0;
      phase_tick <= 1'b0;
    end else begin
      sync_out   <= 32'(cnt_r) < (period >> 1);
      phase_tick <= 32'(cnt_r) == offset;
    end
  end
endmodule

/* hw/vout_slew.sv */
module vout_slew #(
  parameter int TICK_CYC = 100
) (
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic [15:0] init_mv,
  input  wire logic [15:0] dest_mv,
  input  wire logic [15:0] rate,
  output logic [15:0]      target_mv
);
  logic [15:0] tick_r;
  logic [15:0] acc_r;
  logic        tick;

  if (TICK_CYC < 1 || TICK_CYC > 65535) begin : g_chk
    $error("slew tick out of range");
  end

  assign tick = tick_r == 16'(TICK_CYC - 1);

  always_ff @(posedge clk) begin
    if (srst || tick) tick_r <= 16'h0000;
    else tick_r <= tick_r + 16'h0001;
  end

  // rate is mV per ms; at most one mV per us, faster rates saturate
  always_ff @(posedge clk) begin
    if (srst) begin
      acc_r     <= 16'h0000;
      target_mv <= init_mv;
    end else if (target_mv == dest_mv) begin
      acc_r <= 16'h0000;
    end else if (tick) begin
      if (acc_r + rate >= conv_mgmt_pkg::SLEW_ACC_UNIT) begin
        acc_r <= 16'h0000;
        target_mv <= (dest_mv > target_mv) ? target_mv + 16'h0001 : target_mv - 16'h0001;
      end else begin
        acc_r <= acc_r + rate;
      end
    end
  end
endmodule

/* hw/conv_mgmt.sv */
// Notes on behaviour
// RULE_01: only one module on a shared sync line drives it; the rest follow.
// RULE_02: sync enable and driver/follower come from the header pin function word.
// RULE_03: interleave only across modules all locked to the shared sync line.
// RULE_04: 16-bit interleave word holds group, group size and order; resets 0x0021.
// RULE_05: phase shift equals 360 degrees times order over group size.
// RULE_06: switching frequency resets to 180 kHz; writes accepted only within 160-200 kHz.
// RULE_07: power good stays not-good during ramp-up and any fault.
// RULE_08: power good asserts above on threshold, drops below off threshold, both programmable.
// RULE_09: power good pin is push-pull after reset, open-drain when selected. Parallel variants reset to 0x06, which sets bit 1, so open-drain.
// RULE_10: polarity code 00 gives active low pin, 01 active high.
// RULE_11: status word flag shows good only within tolerance and without fault.
// RULE_12: wired power good pins should use open-drain drive.
// RULE_13: load-based voltage picks one of three levels using four current thresholds.
// RULE_14: level changes slew at the programmed transition rate.
// RULE_15: rise time starts at default, scaled by factor chosen from capacitance limits.
// RULE_16: loop parameters change only when capacitance exceeds third limit, at window end.
// RULE_17: header pin function resets to 0x04, or 0x06 on parallel variants.
// RULE_18: bus address is strap base plus programmed offset.
// RULE_19: power good compares output with both thresholds and holds between them.
// RULE_20: level steps up above rising threshold, down below falling threshold.
module conv_mgmt #(
  parameter bit          PARALLEL_VARIANT = 1'b0,
  parameter logic [6:0]  ADDR_ROOT        = 7'h10,
  parameter logic [15:0] PG_TOL_MV        = 16'h01f4
) (
  // clock and reset
  input  wire logic        REF_CLK,
  input  wire logic        SRST,
  // command port
  input  wire logic [7:0]  CMD_CODE,
  input  wire logic        CMD_WR,
  input  wire logic [15:0] CMD_WDATA,
  input  wire logic        CMD_RD,
  output logic [15:0]      CMD_RDATA,
  output logic             CMD_RVALID,
  output logic             CMD_ERR,
  // measurements from the power stage
  input  wire logic [15:0] VOUT_MV,
  input  wire logic [15:0] IOUT_MA,
  input  wire logic        FAULT_ACTIVE,
  input  wire logic        RAMP_ACTIVE,
  input  wire logic [15:0] CAP_VALUE,
  // decoded strap levels
  input  wire logic [2:0]  STRAP_LEVEL_LOW,
  input  wire logic [2:0]  STRAP_LEVEL_HIGH,
  // pin 12, power good or sync
  input  wire logic        PGOOD_OR_SYNC_PIN_IN,
  output logic             PGOOD_OR_SYNC_PIN_OUT,
  output logic             PGOOD_OR_SYNC_PIN_OE_N,
  // pin 9, address strap or sync
  input  wire logic        ADDRESS_STRAP_PIN_HIGH_IN,
  output logic             ADDRESS_STRAP_PIN_HIGH_OUT,
  output logic             ADDRESS_STRAP_PIN_HIGH_OE_N,
  // converter control
  output logic             SWITCH_PHASE_TICK,
  output logic [15:0]      SWITCH_FREQ_KHZ,
  output logic [15:0]      VOUT_TARGET_MV,
  output logic [15:0]      RISE_TIME,
  output logic             LOOP_ALT_SEL,
  output logic             CAP_WINDOW,
  output logic             POWER_GOOD,
  output logic [6:0]       BUS_ADDRESS
);
  logic [15:0] cfg_r [conv_mgmt_pkg::NCFG];
  logic [15:0] pin_cfg_rst;
  logic        hit;
  logic [4:0]  hit_idx;
  logic        fsw_ok;
  logic [15:0] status_word;

  logic        sync_en, sync_drv, sync_on_pg_pin;
  logic        sync_in, sync_out;
  logic        open_drain;
  logic        pg_r, pg_level, in_tol;
  logic [15:0] vout_err;

  conv_mgmt_pkg::bus_level_t lvl_r, lvl_nxt;
  logic [15:0] lvl_dest;

  conv_mgmt_pkg::cap_win_t win_r, win_nxt;
  logic        win_end;
  logic [7:0]  factor_nxt;
  logic [23:0] rise_prod;

  logic [6:0]  strap_base_r;
  logic        strap_taken_r;

  if (PG_TOL_MV == 16'h0000) begin : g_chk
    $error("power good tolerance must be non-zero");
  end

  // command decode
  always_comb begin
    hit     = 1'b0;
    hit_idx = 5'h00;
    for (int i = 0; i < conv_mgmt_pkg::NCFG; i++) begin
      if (CMD_CODE == conv_mgmt_pkg::CFG_CODE[i]) begin
        hit     = 1'b1;
        hit_idx = 5'(i);
      end
    end
  end

  assign fsw_ok = CMD_WDATA >= conv_mgmt_pkg::FSW_MIN_KHZ &&
                  CMD_WDATA <= conv_mgmt_pkg::FSW_MAX_KHZ; // RULE_06
  assign pin_cfg_rst = PARALLEL_VARIANT ? conv_mgmt_pkg::PIN_CFG_PARALLEL
                                        : conv_mgmt_pkg::PIN_CFG_STANDALONE; // RULE_17

  // configuration store; one word per command code
  generate
    for (genvar g = 0; g < conv_mgmt_pkg::NCFG; g++) begin : g_cfg
      always_ff @(posedge REF_CLK) begin
        if (SRST) begin
          if (g == conv_mgmt_pkg::IDX_PIN_CFG) cfg_r[g] <= pin_cfg_rst; // RULE_17
          else cfg_r[g] <= conv_mgmt_pkg::CFG_RESET[g]; // RULE_04
        end else if (CMD_WR && hit && hit_idx == 5'(g)) begin
          if (g != conv_mgmt_pkg::IDX_FSW || fsw_ok) begin // RULE_06
            cfg_r[g] <= CMD_WDATA & conv_mgmt_pkg::CFG_MASK[g];
          end
        end
      end
    end
  endgenerate

  // read answer one cycle after the request; refused writes flagged
  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      CMD_RDATA  <= 16'h0000;
      CMD_RVALID <= 1'b0;
      CMD_ERR    <= 1'b0;
    end else begin
      CMD_RVALID <= CMD_RD;
      CMD_ERR    <= 1'b0;
      if (CMD_RD) begin
        if (CMD_CODE == conv_mgmt_pkg::CMD_STATUS_WORD) CMD_RDATA <= status_word;
        else if (hit) CMD_RDATA <= cfg_r[hit_idx];
        else begin
          CMD_RDATA <= 16'h0000;
          CMD_ERR   <= 1'b1;
        end
      end else if (CMD_WR) begin
        CMD_ERR <= !hit || (hit_idx == 5'(conv_mgmt_pkg::IDX_FSW) && !fsw_ok);
      end
    end
  end

  // sync and interleave
  assign sync_en        = cfg_r[conv_mgmt_pkg::IDX_PIN_CFG][conv_mgmt_pkg::PIN_SYNC_EN_BIT];
  assign sync_drv       = cfg_r[conv_mgmt_pkg::IDX_PIN_CFG][conv_mgmt_pkg::PIN_SYNC_DRV_BIT];
  assign sync_on_pg_pin = !cfg_r[conv_mgmt_pkg::IDX_PIN_CFG][conv_mgmt_pkg::PIN_PG_FUNC_BIT];
  assign open_drain     = cfg_r[conv_mgmt_pkg::IDX_PIN_CFG][conv_mgmt_pkg::PIN_OD_BIT];
  assign sync_in = sync_on_pg_pin ? PGOOD_OR_SYNC_PIN_IN : ADDRESS_STRAP_PIN_HIGH_IN; // RULE_02

  switch_phase_timer #(
    .CLK_KHZ_P (conv_mgmt_pkg::CLK_KHZ)
  ) u_timer (
    .clk        (REF_CLK),
    .srst       (SRST),
    .freq_khz   (cfg_r[conv_mgmt_pkg::IDX_FSW]),
    .sync_en    (sync_en),
    .sync_drv   (sync_drv),
    .sync_in    (sync_in),
    .order      (cfg_r[conv_mgmt_pkg::IDX_INTERLEAVE][conv_mgmt_pkg::IL_ORDER_LSB +: 4]), // RULE_05
    .num        (cfg_r[conv_mgmt_pkg::IDX_INTERLEAVE][conv_mgmt_pkg::IL_NUM_LSB +: 4]),
    .sync_out   (sync_out),
    .phase_tick (SWITCH_PHASE_TICK)
  );

  assign SWITCH_FREQ_KHZ = cfg_r[conv_mgmt_pkg::IDX_FSW];

  // power good with hysteresis between the two thresholds
  always_ff @(posedge REF_CLK) begin
    if (SRST) pg_r <= 1'b0;
    else if (RAMP_ACTIVE || FAULT_ACTIVE) pg_r <= 1'b0; // RULE_07
    else if (VOUT_MV > cfg_r[conv_mgmt_pkg::IDX_PG_ON]) pg_r <= 1'b1; // RULE_08 RULE_19
    else if (VOUT_MV < cfg_r[conv_mgmt_pkg::IDX_PG_OFF]) pg_r <= 1'b0; // RULE_08 RULE_19
  end

  assign POWER_GOOD = pg_r;
  assign pg_level = (cfg_r[conv_mgmt_pkg::IDX_PG_POL][7:0] == conv_mgmt_pkg::POL_ACTIVE_HIGH)
                    ? pg_r : !pg_r; // RULE_10

  // pin drive; only one end per line may be set to drive sync
  always_comb begin
    PGOOD_OR_SYNC_PIN_OUT       = 1'b0;
    PGOOD_OR_SYNC_PIN_OE_N      = 1'b1;
    ADDRESS_STRAP_PIN_HIGH_OUT  = 1'b0;
    ADDRESS_STRAP_PIN_HIGH_OE_N = 1'b1;
    if (sync_on_pg_pin) begin
      if (sync_en && sync_drv) begin // RULE_01 RULE_02
        PGOOD_OR_SYNC_PIN_OUT  = sync_out;
        PGOOD_OR_SYNC_PIN_OE_N = 1'b0;
      end
    end else begin
      if (open_drain) begin // RULE_09
        PGOOD_OR_SYNC_PIN_OUT  = 1'b0;
        PGOOD_OR_SYNC_PIN_OE_N = pg_level;
      end else begin
        PGOOD_OR_SYNC_PIN_OUT  = pg_level;
        PGOOD_OR_SYNC_PIN_OE_N = 1'b0;
      end
      if (sync_en && sync_drv) begin // RULE_01 RULE_02
        ADDRESS_STRAP_PIN_HIGH_OUT  = sync_out;
        ADDRESS_STRAP_PIN_HIGH_OE_N = 1'b0;
      end
    end
  end

  // status flag: bit is set while not good
  assign vout_err = (VOUT_MV > VOUT_TARGET_MV) ? VOUT_MV - VOUT_TARGET_MV
                                               : VOUT_TARGET_MV - VOUT_MV;
  assign in_tol = vout_err <= PG_TOL_MV;
  always_comb begin
    status_word = 16'h0000;
    status_word[conv_mgmt_pkg::STATUS_PG_N_BIT]  = !(pg_r && in_tol && !FAULT_ACTIVE); // RULE_11
    status_word[conv_mgmt_pkg::STATUS_FAULT_BIT] = FAULT_ACTIVE;
  end

  // load-based level selection
  always_comb begin
    lvl_nxt = lvl_r;
    case (lvl_r)
      conv_mgmt_pkg::LVL_LOW: begin
        if (IOUT_MA > cfg_r[conv_mgmt_pkg::IDX_I_LO_MID]) lvl_nxt = conv_mgmt_pkg::LVL_MID; // RULE_20
      end
      conv_mgmt_pkg::LVL_MID: begin
        if (IOUT_MA > cfg_r[conv_mgmt_pkg::IDX_I_MID_HI]) lvl_nxt = conv_mgmt_pkg::LVL_HIGH;
        else if (IOUT_MA < cfg_r[conv_mgmt_pkg::IDX_I_MID_LO]) lvl_nxt = conv_mgmt_pkg::LVL_LOW;
      end
      conv_mgmt_pkg::LVL_HIGH: begin
        if (IOUT_MA < cfg_r[conv_mgmt_pkg::IDX_I_HI_MID]) lvl_nxt = conv_mgmt_pkg::LVL_MID; // RULE_20
      end
      default: lvl_nxt = conv_mgmt_pkg::LVL_HIGH;
    endcase
  end

  // disabled mode parks on the normal setpoint
  always_ff @(posedge REF_CLK) begin
    if (SRST) lvl_r <= conv_mgmt_pkg::LVL_HIGH;
    else if (!cfg_r[conv_mgmt_pkg::IDX_LBV_EN][0]) lvl_r <= conv_mgmt_pkg::LVL_HIGH;
    else if (RAMP_ACTIVE || FAULT_ACTIVE) lvl_r <= lvl_r;
    else lvl_r <= lvl_nxt; // RULE_13
  end

  always_comb begin
    case (lvl_r)
      conv_mgmt_pkg::LVL_LOW:  lvl_dest = cfg_r[conv_mgmt_pkg::IDX_LBV_V1];
      conv_mgmt_pkg::LVL_MID:  lvl_dest = cfg_r[conv_mgmt_pkg::IDX_LBV_V2];
      default:                 lvl_dest = cfg_r[conv_mgmt_pkg::IDX_VOUT_SET]; // RULE_13
    endcase
  end

  vout_slew #(
    .TICK_CYC (conv_mgmt_pkg::SLEW_TICK_CYC)
  ) u_slew (
    .clk       (REF_CLK),
    .srst      (SRST),
    .init_mv   (conv_mgmt_pkg::CFG_RESET[conv_mgmt_pkg::IDX_VOUT_SET]),
    .dest_mv   (lvl_dest),
    .rate      (cfg_r[conv_mgmt_pkg::IDX_VOUT_RATE]), // RULE_14
    .target_mv (VOUT_TARGET_MV)
  );

  // capacitance measurement window on the ramp
  always_comb begin
    win_nxt = win_r;
    case (win_r)
      conv_mgmt_pkg::WIN_IDLE: begin
        if (RAMP_ACTIVE && VOUT_MV >= cfg_r[conv_mgmt_pkg::IDX_CAP_VSTART])
          win_nxt = conv_mgmt_pkg::WIN_OPEN;
      end
      conv_mgmt_pkg::WIN_OPEN: begin
        if (!RAMP_ACTIVE) win_nxt = conv_mgmt_pkg::WIN_IDLE;
        else if (VOUT_MV >= cfg_r[conv_mgmt_pkg::IDX_CAP_VEND]) win_nxt = conv_mgmt_pkg::WIN_DONE;
      end
      conv_mgmt_pkg::WIN_DONE: begin
        if (!RAMP_ACTIVE) win_nxt = conv_mgmt_pkg::WIN_IDLE;
      end
      default: win_nxt = conv_mgmt_pkg::WIN_IDLE;
    endcase
  end

  always_ff @(posedge REF_CLK) begin
    if (SRST) win_r <= conv_mgmt_pkg::WIN_IDLE;
    else win_r <= win_nxt;
  end

  assign CAP_WINDOW = win_r == conv_mgmt_pkg::WIN_OPEN;
  assign win_end    = CAP_WINDOW && win_nxt == conv_mgmt_pkg::WIN_DONE;

  // an aborted window leaves the factor at unity for that ramp
  always_comb begin
    factor_nxt = conv_mgmt_pkg::FACTOR_UNITY;
    if (CAP_VALUE > cfg_r[conv_mgmt_pkg::IDX_LIM3])
      factor_nxt = cfg_r[conv_mgmt_pkg::IDX_K3][7:0];
    else if (CAP_VALUE > cfg_r[conv_mgmt_pkg::IDX_LIM2])
      factor_nxt = cfg_r[conv_mgmt_pkg::IDX_K12][15:8];
    else if (CAP_VALUE > cfg_r[conv_mgmt_pkg::IDX_LIM1])
      factor_nxt = cfg_r[conv_mgmt_pkg::IDX_K12][7:0]; // RULE_15
  end

  assign rise_prod = cfg_r[conv_mgmt_pkg::IDX_TON_RISE] * factor_nxt;

  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      RISE_TIME <= conv_mgmt_pkg::CFG_RESET[conv_mgmt_pkg::IDX_TON_RISE];
    end else if (win_r == conv_mgmt_pkg::WIN_IDLE && !RAMP_ACTIVE) begin
      RISE_TIME <= cfg_r[conv_mgmt_pkg::IDX_TON_RISE]; // RULE_15
    end else if (win_end && cfg_r[conv_mgmt_pkg::IDX_K3][conv_mgmt_pkg::K3_EN_ART_BIT]) begin
      RISE_TIME <= rise_prod[19:4]; // RULE_15
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (SRST) LOOP_ALT_SEL <= 1'b0;
    else if (win_end) begin
      LOOP_ALT_SEL <= cfg_r[conv_mgmt_pkg::IDX_K3][conv_mgmt_pkg::K3_EN_LLC_BIT] &&
                      CAP_VALUE > cfg_r[conv_mgmt_pkg::IDX_LIM3]; // RULE_16
    end
  end

  // straps caught once, on the first edge after reset release
  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      strap_taken_r <= 1'b0;
      strap_base_r  <= 7'h00;
    end else if (!strap_taken_r) begin
      strap_taken_r <= 1'b1;
      strap_base_r  <= ADDR_ROOT + {1'b0, STRAP_LEVEL_HIGH, STRAP_LEVEL_LOW};
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (SRST) BUS_ADDRESS <= 7'h00;
    else BUS_ADDRESS <= strap_base_r + cfg_r[conv_mgmt_pkg::IDX_ADDR_OFS][6:0]; // RULE_18
  end
endmodule

/* dv/conv_mgmt_properties.sv */
module conv_mgmt_checker (
  // clock, reset and command port
  input wire logic        REF_CLK,
  input wire logic        SRST,
  input wire logic [7:0]  CMD_CODE,
  input wire logic        CMD_WR,
  input wire logic [15:0] CMD_WDATA,
  input wire logic        CMD_RD,
  input wire logic        CMD_RVALID,
  input wire logic        CMD_ERR,
  // power stage and control outputs
  input wire logic [15:0] VOUT_MV,
  input wire logic        FAULT_ACTIVE,
  input wire logic        RAMP_ACTIVE,
  input wire logic [15:0] SWITCH_FREQ_KHZ,
  input wire logic [15:0] VOUT_TARGET_MV,
  input wire logic        LOOP_ALT_SEL,
  input wire logic        CAP_WINDOW,
  input wire logic        POWER_GOOD
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (SRST);
  // thresholds assume the reset on/off levels, never reprogrammed by the bench
  wire logic fsw_wr = CMD_WR && !CMD_RD && CMD_CODE == 8'h33;
  wire logic bad    = CMD_WDATA < 16'h00a0 || CMD_WDATA > 16'h00c8;
  wire logic quiet  = !FAULT_ACTIVE && !RAMP_ACTIVE;
  wire logic band   = VOUT_MV >= 16'h1388 && VOUT_MV <= 16'h1f40;

  a_read_answer: assert property (CMD_RD |=> CMD_RVALID)
    else $error("read not answered");
  a_pg_not_good: assert property (!quiet |=> !POWER_GOOD)
    else $error("power good during ramp or fault");
  a_pg_on_level: assert property (quiet && VOUT_MV > 16'h1f40 |=> POWER_GOOD)
    else $error("power good not raised");
  a_pg_off_level: assert property (VOUT_MV < 16'h1388 |=> !POWER_GOOD)
    else $error("power good not dropped");
  a_pg_hold: assert property (quiet && band |=> $stable(POWER_GOOD))
    else $error("power good moved inside band");
  a_fsw_refuse: assert property (fsw_wr && bad |=> CMD_ERR && $stable(SWITCH_FREQ_KHZ))
    else $error("bad frequency taken");
  a_fsw_accept: assert property (fsw_wr && !bad |=>
    !CMD_ERR && SWITCH_FREQ_KHZ == $past(CMD_WDATA))
    else $error("good frequency refused");
  a_loop_at_end: assert property ($changed(LOOP_ALT_SEL) |->
    $past(CAP_WINDOW) && !CAP_WINDOW)
    else $error("loop select moved outside window end");
  a_slew_step: assert property ($changed(VOUT_TARGET_MV) |->
    VOUT_TARGET_MV - $past(VOUT_TARGET_MV) inside {16'h0001, 16'hffff})
    else $error("target jumped");

  c_refuse: cover property (fsw_wr && bad ##1 CMD_ERR);
  c_pg_up: cover property ($rose(POWER_GOOD));
  c_loop: cover property ($rose(LOOP_ALT_SEL));
endmodule

/* dv/sync_peer.sv */
module sync_peer #(
  parameter int PERIOD = 555
) (
  // clock and enable
  input  wire logic clk,
  input  wire logic run,
  // shared sync line
  output logic      sync
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt = 0;
  // lone source on the line while the device follows; held low when idle
  always @(posedge clk) begin
    if (!run) begin
      cnt <= 0;
      sync <= 1'b0;
    end else begin
      cnt <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
      sync <= cnt < PERIOD / 2;
    end
  end
endmodule

/* dv/conv_mgmt_tb.sv */
module conv_mgmt_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        REF_CLK, SRST, CMD_WR, CMD_RD, FAULT_ACTIVE, RAMP_ACTIVE, run;
  logic        CMD_RVALID, CMD_ERR, SWITCH_PHASE_TICK, LOOP_ALT_SEL, CAP_WINDOW, POWER_GOOD;
  logic        pg_out, pg_oe_n, a9_out, a9_oe_n, peer_sync;
  logic [7:0]  CMD_CODE;
  logic [15:0] CMD_WDATA, VOUT_MV, IOUT_MA, CAP_VALUE, CMD_RDATA;
  logic [15:0] SWITCH_FREQ_KHZ, VOUT_TARGET_MV, RISE_TIME;
  logic [2:0]  sl, sh;
  logic [6:0]  BUS_ADDRESS;
  logic [16:0] exp_q [$];
  int          n_errors = 0, n_compared = 0;
  // pin 12 has a pull-up for open-drain use
  wire logic   pin12 = !pg_oe_n ? pg_out : 1'b1;
  wire logic   pin9 = !a9_oe_n ? a9_out : peer_sync;

  conv_mgmt dut (
    .REF_CLK, .SRST, .CMD_CODE, .CMD_WR, .CMD_WDATA, .CMD_RD, .CMD_RDATA, .CMD_RVALID,
    .CMD_ERR, .VOUT_MV, .IOUT_MA, .FAULT_ACTIVE, .RAMP_ACTIVE, .CAP_VALUE,
    .STRAP_LEVEL_LOW(sl), .STRAP_LEVEL_HIGH(sh), .PGOOD_OR_SYNC_PIN_IN(pin12),
    .PGOOD_OR_SYNC_PIN_OUT(pg_out), .PGOOD_OR_SYNC_PIN_OE_N(pg_oe_n),
    .ADDRESS_STRAP_PIN_HIGH_IN(pin9), .ADDRESS_STRAP_PIN_HIGH_OUT(a9_out),
    .ADDRESS_STRAP_PIN_HIGH_OE_N(a9_oe_n), .SWITCH_PHASE_TICK, .SWITCH_FREQ_KHZ,
    .VOUT_TARGET_MV, .RISE_TIME, .LOOP_ALT_SEL, .CAP_WINDOW, .POWER_GOOD, .BUS_ADDRESS);
  sync_peer peer (.clk(REF_CLK), .run(run), .sync(peer_sync));

  initial begin
    REF_CLK = 1'b0;
    forever #5 REF_CLK = ~REF_CLK;
  end

  task automatic results();
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic check(input logic [16:0] got, input logic [16:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] c, input logic [15:0] d, input logic e);
    CMD_CODE = c;
    CMD_WDATA = d;
    CMD_WR = 1'b1;
    @(negedge REF_CLK);
    CMD_WR = 1'b0;
    check(17'(CMD_ERR), 17'(e));
    @(negedge REF_CLK);
  endtask

  task automatic rd(input logic [7:0] c, input logic [15:0] d, input logic e);
    exp_q.push_back({e, d});
    CMD_CODE = c;
    CMD_RD = 1'b1;
    @(negedge REF_CLK);
    CMD_RD = 1'b0;
    @(negedge REF_CLK);
  endtask

  always @(negedge REF_CLK) if (CMD_RVALID === 1'b1) check({CMD_ERR, CMD_RDATA}, exp_q.pop_front());

  task automatic settle(input logic [15:0] v);
    int n = 0;
    IOUT_MA = v;
    while (VOUT_TARGET_MV !== exp_q[0][15:0] && n < 3000) begin
      @(negedge REF_CLK);
      n++;
    end
  endtask

  task automatic phase(input logic [15:0] il, input int e);
    int n = 0;
    wr(8'h37, il, 1'b0);
    repeat (1200) @(negedge REF_CLK);
    @(posedge peer_sync);
    while (SWITCH_PHASE_TICK !== 1'b1 && n < 600) begin
      @(negedge REF_CLK);
      n++;
    end
    check(17'(n >= e && n <= e + 4), 17'h1);
  endtask

  initial begin
    #300us;
    n_errors++;
    results();
  end

  initial begin
    logic [15:0] fv [5], rt [4];
    logic [15:0] f, d, v, cap;
    logic        pg, lvl;
    time         t;
    void'($urandom(41));
    {CMD_CODE, CMD_WDATA, CMD_WR, CMD_RD, IOUT_MA, CAP_VALUE} = '0;
    {VOUT_MV, FAULT_ACTIVE, RAMP_ACTIVE, run} = '0;
    {sh, sl} = 6'($urandom);
    SRST = 1'b1;
    repeat (6) @(negedge REF_CLK);
    SRST = 1'b0;
    rd(8'h37, 16'h0021, 1'b0);
    rd(8'hd0, 16'h0000, 1'b0);
    rd(8'hf9, 16'h0004, 1'b0);
    rd(8'h33, 16'h00b4, 1'b0);
    rd(8'h02, 16'h0000, 1'b1);
    wr(8'h79, 16'h0000, 1'b1);
    d = 16'($urandom);
    wr(8'hee, d, 1'b0);
    rd(8'hee, {8'h00, d[7:0]}, 1'b0);
    check(17'(BUS_ADDRESS), 17'(7'(7'h10 + {sh, sl} + d[6:0])));
    fv = '{16'h009f, 16'h00a0, 16'h00c8, 16'h00c9, 16'($urandom_range(200, 160))};
    f = 16'h00b4;
    foreach (fv[i]) begin
      wr(8'h33, fv[i], fv[i] < 16'h00a0 || fv[i] > 16'h00c8);
      if (fv[i] >= 16'h00a0 && fv[i] <= 16'h00c8) f = fv[i];
      check(17'(SWITCH_FREQ_KHZ), 17'(f));
    end
    wr(8'h33, 16'h00b4, 1'b0);
    // {vout, fault, ramp, expected good} walks through hysteresis and faults
    foreach (fv[i]) begin
      {v, FAULT_ACTIVE, RAMP_ACTIVE, pg} = i[0] ? {16'h1770, i[1], 1'b0, !i[1] && i < 4}
        : {i == 2 ? 16'h0fa0 : 16'h2ee0, 1'b0, i == 4, i == 0};
      VOUT_MV = v;
      repeat (2) @(negedge REF_CLK);
      check(17'({POWER_GOOD, pg_out, pg_oe_n}), {14'h0, pg, !pg, 1'b0});
      rd(8'h79, {4'h0, !(pg && v == 16'h2ee0 && !FAULT_ACTIVE), 10'h0, FAULT_ACTIVE}, 1'b0);
    end
    for (int i = 0; i < 8; i++) begin
      {VOUT_MV, RAMP_ACTIVE} = {i[2] ? 16'h2ee0 : 16'h0000, 1'b0};
      wr(8'hd0, {15'h0, i[0]}, 1'b0);
      wr(8'hf9, i[1] ? 16'h0006 : 16'h0004, 1'b0);
      @(negedge REF_CLK);
      lvl = i[0] ? i[2] : !i[2];
      check(17'({pg_out, pg_oe_n, pin12}), 17'({lvl & !i[1], lvl & i[1], lvl}));
    end
    wr(8'hd0, 16'h0000, 1'b0);
    wr(8'hf6, 16'h0320, 1'b0);
    rt = '{16'h00c8, 16'h0096, 16'h007d, 16'h0064};
    for (int i = 0; i < 4; i++) begin
      cap = 16'(i == 3 ? 0 : 3001 - 1000 * i);
      CAP_VALUE = 16'(cap + $urandom_range(998));
      {RAMP_ACTIVE, VOUT_MV} = {1'b1, 16'h07d0};
      repeat (3) @(negedge REF_CLK);
      check(17'({POWER_GOOD, CAP_WINDOW}), 17'h1);
      VOUT_MV = 16'h2328;
      repeat (3) @(negedge REF_CLK);
      check({LOOP_ALT_SEL, RISE_TIME}, {i == 0, rt[i]});
      {RAMP_ACTIVE, VOUT_MV} = '0;
      repeat (3) @(negedge REF_CLK);
      check(17'(RISE_TIME), 17'h0064);
    end
    wr(8'he0, 16'h2ee6, 1'b0);
    wr(8'he1, 16'h2eeb, 1'b0);
    wr(8'h27, 16'h03e8, 1'b0);
    wr(8'he6, 16'h0001, 1'b0);
    // a spare note carries each awaited target; popped before any read
    exp_q.push_back(17'h02ee6);
    settle(16'h0000);
    check(17'(VOUT_TARGET_MV), 17'h02ee6);
    IOUT_MA = 16'h1194;
    repeat (300) @(negedge REF_CLK);
    check(17'(VOUT_TARGET_MV), 17'h02ee6);
    t = $time;
    exp_q[0] = 17'h02eeb;
    settle(16'h1770);
    check(17'(($time - t) >= 4000 && ($time - t) <= 6000), 17'h1);
    exp_q[0] = 17'h02ee0;
    settle(16'h7530);
    check(17'(VOUT_TARGET_MV), exp_q.pop_front());
    wr(8'hf9, 16'h000c, 1'b0);
    run = 1'b1;
    phase(16'h0021, 277);
    phase(16'h0041, 138);
    phase(16'h0043, 416);
    run = 1'b0;
    for (int k = 0; k < 2; k++) begin
      @(negedge REF_CLK);
      wr(8'hf9, k ? 16'h0018 : 16'h001c, 1'b0);
      @(posedge (a9_oe_n ? pg_out : a9_out));
      t = $time;
      @(posedge (a9_oe_n ? pg_out : a9_out));
      check(17'(($time - t) / 10), 17'h0022b);
      check(17'({a9_oe_n, pg_oe_n}), 17'({k[0], 1'b0}));
    end
    check(17'(exp_q.size()), 17'h0);
    results();
  end
endmodule

bind conv_mgmt conv_mgmt_checker chk (.REF_CLK, .SRST, .CMD_CODE, .CMD_WR, .CMD_WDATA,
  .CMD_RD, .CMD_RVALID, .CMD_ERR, .VOUT_MV, .FAULT_ACTIVE, .RAMP_ACTIVE, .SWITCH_FREQ_KHZ,
  .VOUT_TARGET_MV, .LOOP_ALT_SEL, .CAP_WINDOW, .POWER_GOOD);
